// ---- design/tpwm_pkg.sv ----
`default_nettype none
package tpwm_pkg;
    localparam logic [7:0] TPWM_MAX = 8'h00_FF;
    localparam logic [7:0] TPWM_BOTTOM = 8'h00_00;
    // register byte offsets
    localparam logic [7:0] TPWM_OFF_CTRL = 8'h00_00;
    localparam logic [7:0] TPWM_OFF_COUNT = 8'h00_04;
    localparam logic [7:0] TPWM_OFF_COMPARE = 8'h00_08;
    localparam logic [7:0] TPWM_OFF_STATUS = 8'h00_0C;
    localparam logic [7:0] TPWM_OFF_CLKSRC = 8'h00_10;
    // status bit positions
    localparam int TPWM_ST_OVF = 0;
    localparam int TPWM_ST_CMF = 1;
    // reset values, then bus response codes
    localparam logic [7:0] TPWM_RST_CTRL = 8'h00_00;
    localparam logic [7:0] TPWM_RST_COUNT = 8'h00_00;
    localparam logic [7:0] TPWM_RST_COMPARE = 8'h00_00;
    localparam logic [1:0] TPWM_RESP_OKAY = 2'h0;
    localparam logic [1:0] TPWM_RESP_SLVERR = 2'h2;
    // compare output mode codes
    localparam logic [1:0] TPWM_COM_OFF = 2'h0;
    localparam logic [1:0] TPWM_COM_TOGGLE = 2'h1;
    localparam logic [1:0] TPWM_COM_NONINV = 2'h2;
    localparam logic [1:0] TPWM_COM_INV = 2'h3;

    typedef enum logic [1:0] {
        TPWM_WM_NORMAL = 2'b00,
        TPWM_WM_PHASE = 2'b01,
        TPWM_WM_CTC = 2'b10,
        TPWM_WM_FAST = 2'b11
    } tpwm_wmode_t;

    // control word, bit 7 down to bit 0
    typedef struct packed {
        logic force_match;
        logic waveform_mode_lo;
        logic [1:0] compare_output_mode;
        logic waveform_mode_hi;
        logic [2:0] clock_select;
    } tpwm_ctrl_t;
endpackage
`default_nettype wire

// ---- design/tpwm_prescaler.sv ----
`timescale 1ns/1ps
`default_nettype none
module tpwm_prescaler (
    input wire logic i_clk,
    input wire logic i_rst,
    input wire logic i_src_tick,
    input wire logic [2:0] i_clock_select,
    output logic o_tick
);
    logic [9:0] div_cnt_ff;
    logic tick_ff;

    // mask of low divider bits that must all be ones for a tick
    function automatic logic [9:0] div_mask(input logic [2:0] sel);
        unique case (sel)
            3'h1: div_mask = 10'h000;
            3'h2: div_mask = 10'h007;
            3'h3: div_mask = 10'h01F;
            3'h4: div_mask = 10'h03F;
            3'h5: div_mask = 10'h07F;
            3'h6: div_mask = 10'h0FF;
            3'h7: div_mask = 10'h3FF;
            default: div_mask = 10'h000;
        endcase
    endfunction

    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            div_cnt_ff <= 10'h000;
        end else if (i_src_tick) begin
            div_cnt_ff <= div_cnt_ff + 10'h001;
        end
    end

    // select zero gives no tick at all, counter stops [RULE22]
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            tick_ff <= 1'b0;
        end else begin
            tick_ff <= i_src_tick && (i_clock_select != 3'h0) &&
                ((div_cnt_ff & div_mask(i_clock_select)) == div_mask(i_clock_select));
        end
    end

    assign o_tick = tick_ff;
endmodule
`default_nettype wire

// ---- design/tpwm_timer.sv ----
// Notes on behaviour
// [RULE1] fast pwm sets overflow flag whenever counter is at maximum
// [RULE2] fast pwm: mode two non-inverted, mode three inverted output
// [RULE3] fast pwm: active level on match, opposite level at wrap to zero
// [RULE4] fast pwm period is 256 prescaled timer clocks
// [RULE5] fast pwm compare zero gives one-tick pulse every 256 ticks
// [RULE6] fast pwm compare maximum gives constant level by polarity
// [RULE7] fast pwm mode one toggles on match, fifty percent duty
// [RULE8] fast pwm double-buffers compare value, loaded at bottom
// [RULE9] waveform mode one is dual-slope phase correct counting
// [RULE10] phase correct: clear on up match, set on down match, inverse too
// [RULE11] phase correct is 8-bit, maximum held one tick then reverses
// [RULE12] phase correct: mode two non-inverted, mode three inverted
// [RULE13] phase correct sets overflow flag when counter is at zero
// [RULE14] phase correct period is 510 prescaled timer clocks
// [RULE15] phase correct compare zero/maximum gives constant low/high
// [RULE16] at maximum output forced to up-match level for symmetry
// [RULE17] missed up match still gets symmetry transition at maximum
// [RULE18] counter moves only on timer clock enable, or oscillator ticks
// [RULE19] waveform mode three is fast pwm single-slope
// [RULE20] compare at top with high mode bit: match ignored, top acts
// [RULE21] software must enable pin direction before waveform shows
// [RULE22] clock select zero stops the counter
// [RULE23] compare match flag set on timer tick after the match
// [RULE24] phase correct loads buffered compare value at top only
//
// The AXI4-Lite register port and the placing of the registers are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
module tpwm_timer (
    input wire logic i_clk,
    input wire logic i_rst,
    input wire logic i_s_awvalid,
    output logic o_s_awready,
    input wire logic [7:0] i_s_awaddr,
    input wire logic i_s_wvalid,
    output logic o_s_wready,
    input wire logic [31:0] i_s_wdata,
    input wire logic [3:0] i_s_wstrb,
    output logic o_s_bvalid,
    input wire logic i_s_bready,
    output logic [1:0] o_s_bresp,
    input wire logic i_s_arvalid,
    output logic o_s_arready,
    input wire logic [7:0] i_s_araddr,
    output logic o_s_rvalid,
    input wire logic i_s_rready,
    output logic [31:0] o_s_rdata,
    output logic [1:0] o_s_rresp,
    input wire logic i_osc_tick,
    input wire logic i_pin_dir_out,
    output logic o_compare_output,
    output logic o_compare_output_pin,
    output logic o_compare_output_pin_oe
);
    tpwm_pkg::tpwm_ctrl_t ctrl_ff;
    tpwm_pkg::tpwm_wmode_t wmode;
    logic [7:0] counter_value_ff, nxt_counter_value, compare_buf_ff, compare_act_ff;
    logic count_down_ff, overflow_flag_ff, compare_match_flag_ff, match_pend_ff;
    logic block_match_ff, async_mode_ff, out_ff, timer_clock_enable, match, at_max, inv;
    logic aw_held_ff, w_held_ff;
    logic [7:0] awaddr_ff;
    logic [31:0] wdata_ff;
    logic [3:0] wstrb_ff;
    logic bvalid_ff;
    logic [1:0] bresp_ff;
    logic rvalid_ff;
    logic [31:0] rdata_ff;
    logic [1:0] rresp_ff;
    logic wr_go, wr_ctrl, wr_cnt, wr_cmp, wr_stat, wr_src;

    function automatic logic addr_known(input logic [7:0] a);
        addr_known = (a == tpwm_pkg::TPWM_OFF_CTRL) || (a == tpwm_pkg::TPWM_OFF_COUNT) ||
            (a == tpwm_pkg::TPWM_OFF_COMPARE) || (a == tpwm_pkg::TPWM_OFF_STATUS) ||
            (a == tpwm_pkg::TPWM_OFF_CLKSRC);
    endfunction

    // bus write channel: address and data taken in either order
    assign o_s_awready = !aw_held_ff && !bvalid_ff;
    assign o_s_wready = !w_held_ff && !bvalid_ff;
    assign wr_go = aw_held_ff && w_held_ff && !bvalid_ff;
    assign wr_ctrl = wr_go && (awaddr_ff == tpwm_pkg::TPWM_OFF_CTRL) && wstrb_ff[0];
    assign wr_cnt = wr_go && (awaddr_ff == tpwm_pkg::TPWM_OFF_COUNT) && wstrb_ff[0];
    assign wr_cmp = wr_go && (awaddr_ff == tpwm_pkg::TPWM_OFF_COMPARE) && wstrb_ff[0];
    assign wr_stat = wr_go && (awaddr_ff == tpwm_pkg::TPWM_OFF_STATUS) && wstrb_ff[0];
    assign wr_src = wr_go && (awaddr_ff == tpwm_pkg::TPWM_OFF_CLKSRC) && wstrb_ff[0];

    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            aw_held_ff <= 1'b0;
            w_held_ff <= 1'b0;
            awaddr_ff <= 8'h00_00;
            wdata_ff <= 32'h0000_0000;
            wstrb_ff <= 4'h0;
            bvalid_ff <= 1'b0;
            bresp_ff <= tpwm_pkg::TPWM_RESP_OKAY;
        end else begin
            if (i_s_awvalid && o_s_awready) begin
                aw_held_ff <= 1'b1;
                awaddr_ff <= i_s_awaddr;
            end
            if (i_s_wvalid && o_s_wready) begin
                w_held_ff <= 1'b1;
                wdata_ff <= i_s_wdata;
                wstrb_ff <= i_s_wstrb;
            end
            if (wr_go) begin
                aw_held_ff <= 1'b0;
                w_held_ff <= 1'b0;
                bvalid_ff <= 1'b1;
                bresp_ff <= addr_known(awaddr_ff) ? tpwm_pkg::TPWM_RESP_OKAY :
                    tpwm_pkg::TPWM_RESP_SLVERR;
            end else if (bvalid_ff && i_s_bready) begin
                bvalid_ff <= 1'b0;
            end
        end
    end

    assign o_s_bvalid = bvalid_ff;
    assign o_s_bresp = bresp_ff;

    // bus read channel, one read outstanding
    assign o_s_arready = !rvalid_ff;
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            rvalid_ff <= 1'b0;
            rdata_ff <= 32'h0000_0000;
            rresp_ff <= tpwm_pkg::TPWM_RESP_OKAY;
        end else if (i_s_arvalid && o_s_arready) begin
            rvalid_ff <= 1'b1;
            rresp_ff <= addr_known(i_s_araddr) ? tpwm_pkg::TPWM_RESP_OKAY :
                tpwm_pkg::TPWM_RESP_SLVERR;
            unique case (i_s_araddr)
                // force strobe always reads as zero
                tpwm_pkg::TPWM_OFF_CTRL: rdata_ff <= {24'h00_0000, 1'b0, ctrl_ff[6:0]};
                tpwm_pkg::TPWM_OFF_COUNT: rdata_ff <= {24'h00_0000, counter_value_ff};
                tpwm_pkg::TPWM_OFF_COMPARE: rdata_ff <= {24'h00_0000, compare_buf_ff};
                tpwm_pkg::TPWM_OFF_STATUS: rdata_ff <= {30'h0000_0000,
                    compare_match_flag_ff, overflow_flag_ff};
                tpwm_pkg::TPWM_OFF_CLKSRC: rdata_ff <= {31'h0000_0000, async_mode_ff};
                default: rdata_ff <= 32'h0000_0000;
            endcase
        end else if (rvalid_ff && i_s_rready) begin
            rvalid_ff <= 1'b0;
        end
    end

    assign o_s_rvalid = rvalid_ff;
    assign o_s_rdata = rdata_ff;
    assign o_s_rresp = rresp_ff;

    // control registers; force bit is a one-cycle strobe
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            ctrl_ff <= tpwm_pkg::TPWM_RST_CTRL;
            async_mode_ff <= 1'b0;
        end else begin
            if (wr_ctrl) begin
                ctrl_ff <= tpwm_pkg::tpwm_ctrl_t'(wdata_ff[7:0]);
            end else begin
                ctrl_ff.force_match <= 1'b0;
            end
            if (wr_src) begin
                async_mode_ff <= wdata_ff[0];
            end
        end
    end

    assign wmode = tpwm_pkg::tpwm_wmode_t'({ctrl_ff.waveform_mode_hi, ctrl_ff.waveform_mode_lo});
    assign inv = ctrl_ff.compare_output_mode[0];
    assign at_max = (counter_value_ff == tpwm_pkg::TPWM_MAX);

    // oscillator ticks replace the i/o clock in asynchronous mode [RULE18]
    tpwm_prescaler u_prescaler (
        .i_clk(i_clk),
        .i_rst(i_rst),
        .i_src_tick(async_mode_ff ? i_osc_tick : 1'b1),
        .i_clock_select(ctrl_ff.clock_select),
        .o_tick(timer_clock_enable)
    );

    // a counter write hides the match on the next tick
    // compare at top with high mode bit set never matches in fast pwm or phase correct [RULE20]
    assign match = (counter_value_ff == compare_act_ff) && !block_match_ff &&
        !(ctrl_ff.compare_output_mode[1] && (compare_act_ff == tpwm_pkg::TPWM_MAX) &&
        ((wmode == tpwm_pkg::TPWM_WM_FAST) || (wmode == tpwm_pkg::TPWM_WM_PHASE)));

    always_comb begin
        nxt_counter_value = counter_value_ff;
        unique case (wmode)
            tpwm_pkg::TPWM_WM_PHASE: begin
                // dual slope, each end value held a single tick [RULE9] [RULE11] [RULE14]
                if (!count_down_ff) begin
                    nxt_counter_value = at_max ? counter_value_ff - 8'h01 :
                        counter_value_ff + 8'h01;
                end else begin
                    nxt_counter_value = (counter_value_ff == tpwm_pkg::TPWM_BOTTOM) ?
                        8'h01 : counter_value_ff - 8'h01;
                end
            end
            tpwm_pkg::TPWM_WM_CTC: begin
                nxt_counter_value = match ? tpwm_pkg::TPWM_BOTTOM : counter_value_ff + 8'h01;
            end
            // single slope wraps past maximum [RULE4] [RULE19]
            default: nxt_counter_value = counter_value_ff + 8'h01;
        endcase
    end

    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            counter_value_ff <= tpwm_pkg::TPWM_RST_COUNT;
            count_down_ff <= 1'b0;
            block_match_ff <= 1'b0;
        end else if (wr_cnt) begin
            counter_value_ff <= wdata_ff[7:0];
            block_match_ff <= 1'b1;
        end else if (timer_clock_enable) begin
            counter_value_ff <= nxt_counter_value; // [RULE18]
            block_match_ff <= 1'b0;
            if (wmode != tpwm_pkg::TPWM_WM_PHASE) begin
                count_down_ff <= 1'b0;
            end else if (!count_down_ff && at_max) begin
                count_down_ff <= 1'b1; // [RULE11]
            end else if (count_down_ff && (counter_value_ff == tpwm_pkg::TPWM_BOTTOM)) begin
                count_down_ff <= 1'b0;
            end
        end
    end

    // buffered compare: loaded at maximum in fast pwm and phase correct alike, immediate elsewhere
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            compare_buf_ff <= tpwm_pkg::TPWM_RST_COMPARE;
            compare_act_ff <= tpwm_pkg::TPWM_RST_COMPARE;
        end else begin
            if (wr_cmp) begin
                compare_buf_ff <= wdata_ff[7:0];
            end
            if ((wmode == tpwm_pkg::TPWM_WM_NORMAL) || (wmode == tpwm_pkg::TPWM_WM_CTC)) begin
                compare_act_ff <= compare_buf_ff;
            end else if (timer_clock_enable && at_max && !wr_cnt) begin
                compare_act_ff <= compare_buf_ff; // [RULE8] [RULE24]
            end
        end
    end

    // flags: set wins over a write-one clear in the same cycle
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            overflow_flag_ff <= 1'b0;
            compare_match_flag_ff <= 1'b0;
            match_pend_ff <= 1'b0;
        end else begin
            if (timer_clock_enable && !wr_cnt && (((wmode != tpwm_pkg::TPWM_WM_PHASE) && at_max)
                || ((wmode == tpwm_pkg::TPWM_WM_PHASE) &&
                (counter_value_ff == tpwm_pkg::TPWM_BOTTOM)))) begin
                overflow_flag_ff <= 1'b1; // [RULE1] [RULE13]
            end else if (wr_stat && wdata_ff[tpwm_pkg::TPWM_ST_OVF]) begin
                overflow_flag_ff <= 1'b0;
            end
            if (timer_clock_enable && match_pend_ff) begin
                compare_match_flag_ff <= 1'b1; // [RULE23]
            end else if (wr_stat && wdata_ff[tpwm_pkg::TPWM_ST_CMF]) begin
                compare_match_flag_ff <= 1'b0;
            end
            if (timer_clock_enable) begin
                match_pend_ff <= match && !wr_cnt;
            end
        end
    end

    // waveform output register
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            out_ff <= 1'b0;
        end else if (ctrl_ff.force_match && (wmode == tpwm_pkg::TPWM_WM_NORMAL ||
            wmode == tpwm_pkg::TPWM_WM_CTC)) begin
            unique case (ctrl_ff.compare_output_mode)
                tpwm_pkg::TPWM_COM_TOGGLE: out_ff <= !out_ff;
                tpwm_pkg::TPWM_COM_NONINV: out_ff <= 1'b0;
                tpwm_pkg::TPWM_COM_INV: out_ff <= 1'b1;
                default: out_ff <= out_ff;
            endcase
        end else if (timer_clock_enable && !wr_cnt) begin
            unique case (wmode)
                tpwm_pkg::TPWM_WM_FAST: begin
                    if (ctrl_ff.compare_output_mode[1] && at_max) begin
                        out_ff <= !inv; // [RULE2] [RULE3] [RULE6]
                    end else if (ctrl_ff.compare_output_mode[1] && match) begin
                        out_ff <= inv; // [RULE3] [RULE5]
                    end else if ((ctrl_ff.compare_output_mode == tpwm_pkg::TPWM_COM_TOGGLE)
                        && match) begin
                        out_ff <= !out_ff; // [RULE7]
                    end
                end
                tpwm_pkg::TPWM_WM_PHASE: begin
                    if (ctrl_ff.compare_output_mode[1] && at_max) begin
                        // symmetry around top, covers a missed up match [RULE16] [RULE17]
                        out_ff <= (compare_buf_ff == tpwm_pkg::TPWM_MAX) ? !inv : inv;
                    end else if (ctrl_ff.compare_output_mode[1] && match) begin
                        // bottom belongs to the up slope: compare zero stays at up level
                        out_ff <= (count_down_ff && // [RULE10] [RULE12] [RULE15]
                            (counter_value_ff != tpwm_pkg::TPWM_BOTTOM)) ? !inv : inv;
                    end
                end
                default: begin
                    if (match) begin
                        unique case (ctrl_ff.compare_output_mode)
                            tpwm_pkg::TPWM_COM_TOGGLE: out_ff <= !out_ff;
                            tpwm_pkg::TPWM_COM_NONINV: out_ff <= 1'b0;
                            tpwm_pkg::TPWM_COM_INV: out_ff <= 1'b1;
                            default: out_ff <= out_ff;
                        endcase
                    end
                end
            endcase
        end
    end

    // pin only driven when connected and direction set by software [RULE21]
    assign o_compare_output = out_ff;
    assign o_compare_output_pin = out_ff;
    assign o_compare_output_pin_oe = i_pin_dir_out &&
        (ctrl_ff.compare_output_mode != tpwm_pkg::TPWM_COM_OFF);

    a_fast_wrap_zero: assert property (@(posedge i_clk) disable iff (i_rst) // [RULE3]
        (wmode == tpwm_pkg::TPWM_WM_FAST) && timer_clock_enable && at_max && !wr_cnt
        |=> counter_value_ff == tpwm_pkg::TPWM_BOTTOM)
        else $error("fast pwm did not wrap to zero");
    a_fast_ovf_set: assert property (@(posedge i_clk) disable iff (i_rst) // [RULE1]
        (wmode == tpwm_pkg::TPWM_WM_FAST) && timer_clock_enable && at_max && !wr_cnt
        |=> overflow_flag_ff)
        else $error("overflow flag not set at maximum");
    a_phase_reverse: assert property (@(posedge i_clk) disable iff (i_rst) // [RULE11]
        (wmode == tpwm_pkg::TPWM_WM_PHASE) && !count_down_ff && timer_clock_enable &&
        at_max && !wr_cnt |=> count_down_ff && (counter_value_ff == 8'hFE))
        else $error("phase correct did not reverse at maximum");
    a_phase_ovf_bottom: assert property (@(posedge i_clk) disable iff (i_rst) // [RULE13]
        (wmode == tpwm_pkg::TPWM_WM_PHASE) && timer_clock_enable && !wr_cnt &&
        (counter_value_ff == tpwm_pkg::TPWM_BOTTOM) |=> overflow_flag_ff)
        else $error("overflow flag not set at bottom");
    a_stop_no_count: assert property (@(posedge i_clk) disable iff (i_rst) // [RULE22]
        (ctrl_ff.clock_select == 3'h0) && $stable(ctrl_ff) && !wr_cnt
        |=> $stable(counter_value_ff))
        else $error("counter moved with no clock source");
    a_fast_set_bottom: assert property (@(posedge i_clk) disable iff (i_rst) // [RULE2]
        (wmode == tpwm_pkg::TPWM_WM_FAST) && ctrl_ff.compare_output_mode[1] &&
        timer_clock_enable && at_max && !wr_cnt && !ctrl_ff.force_match
        |=> out_ff == !$past(inv))
        else $error("fast pwm output wrong at bottom");
    a_phase_top_level: assert property (@(posedge i_clk) disable iff (i_rst) // [RULE16]
        (wmode == tpwm_pkg::TPWM_WM_PHASE) && ctrl_ff.compare_output_mode[1] &&
        timer_clock_enable && at_max && !wr_cnt && !ctrl_ff.force_match
        |=> out_ff == (($past(compare_buf_ff) == tpwm_pkg::TPWM_MAX) ^ $past(inv)))
        else $error("phase correct top level not symmetric");
    a_match_flag_next: assert property (@(posedge i_clk) disable iff (i_rst) // [RULE23]
        timer_clock_enable && match_pend_ff |=> compare_match_flag_ff)
        else $error("compare match flag not set after match");
    a_fast_buf_hold: assert property (@(posedge i_clk) disable iff (i_rst) // [RULE8]
        (wmode == tpwm_pkg::TPWM_WM_FAST) && $stable(wmode) &&
        !(timer_clock_enable && at_max) |=> $stable(compare_act_ff))
        else $error("fast pwm compare value changed mid period");

    c_fast_wrap: cover property (@(posedge i_clk) disable iff (i_rst)
        (wmode == tpwm_pkg::TPWM_WM_FAST) && timer_clock_enable && at_max);
    c_phase_down: cover property (@(posedge i_clk) disable iff (i_rst)
        (wmode == tpwm_pkg::TPWM_WM_PHASE) && count_down_ff && match && timer_clock_enable);
    c_flag_clear: cover property (@(posedge i_clk) disable iff (i_rst)
        wr_stat && overflow_flag_ff ##1 !overflow_flag_ff);
endmodule
`default_nettype wire

// ---- dv/tb_tpwm_timer.sv ----
`timescale 1ns/1ps
`default_nettype none
module tb_tpwm_timer;
    logic i_clk = 1'b0, i_rst = 1'b1, awv = 1'b0, wv = 1'b0, bry = 1'b0;
    logic arv = 1'b0, rry = 1'b0, osc = 1'b0, dir = 1'b0;
    logic [7:0] awa = 8'h00, ara = 8'h00, c;
    logic [31:0] wd = 32'h0000_0000, rdata, r;
    logic aw_r, w_r, bv, ar_r, rv, oc, pin, oe;
    logic [1:0] br, rr;
    logic [33:0] expq[$];
    int miscompares = 0, checks_done = 0, seed = 63252;

    tpwm_timer tpwm_timer_i (.i_clk(i_clk), .i_rst(i_rst), .i_s_awvalid(awv), .o_s_awready(aw_r),
        .i_s_awaddr(awa), .i_s_wvalid(wv), .o_s_wready(w_r), .i_s_wdata(wd), .i_s_wstrb(4'h1),
        .o_s_bvalid(bv), .i_s_bready(bry), .o_s_bresp(br), .i_s_arvalid(arv), .o_s_arready(ar_r),
        .i_s_araddr(ara), .o_s_rvalid(rv), .i_s_rready(rry), .o_s_rdata(rdata), .o_s_rresp(rr),
        .i_osc_tick(osc), .i_pin_dir_out(dir), .o_compare_output(oc),
        .o_compare_output_pin(pin), .o_compare_output_pin_oe(oe));

    initial begin
        forever #2.5 i_clk = ~i_clk;
    end

    task automatic check(input string n, input logic [33:0] s, input logic [33:0] e);
        checks_done++;
        if (s !== e) begin
            miscompares++;
            $display("[ERR] %s expected %h seen %h", n, e, s);
        end
    endtask

    task automatic summarize();
        $display("checks %0d miscompares %0d", checks_done, miscompares);
        if (miscompares == 0 && checks_done > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    // responses are judged here, in the order they were requested
    always @(posedge i_clk) begin
        if (rv && rry)
            check("read", {rr, rdata}, expq.pop_front());
        if (bv && bry)
            check("bresp", {br, 32'h0000_0000}, expq.pop_front());
    end

    task automatic wr(input logic [7:0] a, input logic [7:0] d,
                      input logic [1:0] e = tpwm_pkg::TPWM_RESP_OKAY);
        @(posedge i_clk);
        expq.push_back({e, 32'h0000_0000});
        awv <= 1'b1;
        awa <= a;
        wv <= 1'b1;
        wd <= {24'h00_0000, d};
        bry <= 1'b1;
        do begin
            @(posedge i_clk);
            if (aw_r)
                awv <= 1'b0;
            if (w_r)
                wv <= 1'b0;
        end while (bv !== 1'b1);
        bry <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] a, input logic [7:0] d,
                      input logic [1:0] e = tpwm_pkg::TPWM_RESP_OKAY);
        @(posedge i_clk);
        expq.push_back({e, 24'h00_0000, d});
        arv <= 1'b1;
        ara <= a;
        rry <= 1'b1;
        do begin
            @(posedge i_clk);
            if (ar_r)
                arv <= 1'b0;
        end while (rv !== 1'b1);
        rry <= 1'b0;
    endtask

    // counts high cycles over one whole period after two settling periods
    task automatic run(input tpwm_pkg::tpwm_wmode_t wm, input logic [1:0] com,
                       input logic [2:0] cs, input logic [7:0] cv);
        int div, per, e, hi, hp;
        div = (cs == 3'h2) ? 8 : 1;
        per = ((wm == tpwm_pkg::TPWM_WM_PHASE) ? 510 : 256) * div;
        e = (wm == tpwm_pkg::TPWM_WM_PHASE) ? 2 * cv : ((cv == 8'hFF) ? 256 : cv + 1);
        if (com == tpwm_pkg::TPWM_COM_TOGGLE) begin
            per = 2 * per;
            e = 256;
        end
        e = e * div;
        if (com == tpwm_pkg::TPWM_COM_INV)
            e = per - e;
        wr(tpwm_pkg::TPWM_OFF_COMPARE, cv);
        wr(tpwm_pkg::TPWM_OFF_CTRL, {1'b0, wm[0], com, wm[1], cs});
        repeat (2 * per) @(posedge i_clk);
        hi = 0;
        hp = 0;
        repeat (per) begin
            @(posedge i_clk);
            hi = hi + ((oc === 1'b1) ? 1 : 0);
            hp = hp + ((pin === 1'b1) ? 1 : 0);
        end
        check("high_cycles", 34'(hi), 34'(e));
        check("pin_high", 34'(hp), 34'(e));
    endtask

    initial begin
        repeat (3) @(posedge i_clk);
        i_rst <= 1'b0;
        rd(tpwm_pkg::TPWM_OFF_CTRL, tpwm_pkg::TPWM_RST_CTRL);
        rd(tpwm_pkg::TPWM_OFF_COUNT, tpwm_pkg::TPWM_RST_COUNT);
        rd(tpwm_pkg::TPWM_OFF_COMPARE, tpwm_pkg::TPWM_RST_COMPARE);
        rd(8'h14, 8'h00, tpwm_pkg::TPWM_RESP_SLVERR);
        wr(8'h14, 8'hA5, tpwm_pkg::TPWM_RESP_SLVERR);
        dir <= 1'b1;
        for (int w = 0; w < 2; w++)
            for (int m = 2; m < 4; m++)
                for (int k = 0; k < 3; k++) begin
                    r = $random(seed);
                    c = (k == 0) ? 8'h00 : ((k == 1) ? (r[7:0] | 8'h01) : 8'hFF);
                    run(w ? tpwm_pkg::TPWM_WM_PHASE : tpwm_pkg::TPWM_WM_FAST, m[1:0], 3'h1, c);
                end
        run(tpwm_pkg::TPWM_WM_FAST, tpwm_pkg::TPWM_COM_TOGGLE, 3'h1, 8'h00);
        run(tpwm_pkg::TPWM_WM_FAST, tpwm_pkg::TPWM_COM_NONINV, 3'h2, 8'h40);
        check("pin_oe", {33'h0, oe}, 34'h1);
        rd(tpwm_pkg::TPWM_OFF_STATUS, 8'h03);
        wr(tpwm_pkg::TPWM_OFF_CTRL, 8'h58);
        wr(tpwm_pkg::TPWM_OFF_STATUS, 8'h03);
        rd(tpwm_pkg::TPWM_OFF_STATUS, 8'h00);
        rd(tpwm_pkg::TPWM_OFF_CTRL, 8'h58);
        wr(tpwm_pkg::TPWM_OFF_COUNT, 8'h10);
        repeat (20) @(posedge i_clk);
        rd(tpwm_pkg::TPWM_OFF_COUNT, 8'h10);
        dir <= 1'b0;
        @(posedge i_clk);
        check("pin_oe", {33'h0, oe}, 34'h0);
        wr(tpwm_pkg::TPWM_OFF_CLKSRC, 8'h01);
        wr(tpwm_pkg::TPWM_OFF_CTRL, 8'h01);
        repeat (20) @(posedge i_clk);
        rd(tpwm_pkg::TPWM_OFF_COUNT, 8'h10);
        repeat (10) begin
            @(posedge i_clk);
            osc <= 1'b1;
            @(posedge i_clk);
            osc <= 1'b0;
            r = $random(seed);
            repeat (r[1:0]) @(posedge i_clk);
        end
        repeat (10) @(posedge i_clk);
        rd(tpwm_pkg::TPWM_OFF_COUNT, 8'h1A);
        summarize();
    end

    // whole run is about 22k cycles
    initial begin
        #250_000;
        miscompares++;
        summarize();
    end
endmodule
`default_nettype wire
